/* File: core/tet_pkg.sv */
package tet_pkg;
    // ********************
    // register map
    // ********************
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_EXPO = 4'h4;
    localparam logic [3:0] ADDR_STAT = 4'h8;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] EXPO_RESET = 32'h0000_0064;
    // ********************
    // scan timing, in pixel periods and lines
    // ********************
    localparam logic [10:0] PX_FULL = 11'd1592;
    localparam logic [10:0] PX_MERGE = 11'd1752;
    localparam logic [10:0] PX_PART = 11'd1552;
    localparam logic [10:0] PX_OUT = 11'd1380;
    localparam logic [10:0] LN_FULL = 11'd1060;
    localparam logic [10:0] LN_FULL_OUT = 11'd1030;
    localparam logic [10:0] LN_MERGE = 11'd565;
    localparam logic [10:0] LN_MERGE_OUT = 11'd515;
    localparam logic [10:0] LN_HALF = 11'd588;
    localparam logic [10:0] LN_HALF_OUT = 11'd512;
    localparam logic [10:0] LN_QUART = 11'd360;
    localparam logic [10:0] LN_QUART_OUT = 11'd256;
    localparam logic [10:0] LN_EIGHTH = 11'd248;
    localparam logic [10:0] LN_EIGHTH_OUT = 11'd128;
    localparam logic [10:0] DUMP_LINES = 11'd133;
    localparam logic [2:0] MULTI_MAX = 3'd6;
    // ********************
    // time constants
    // ********************
    localparam int CLK_PERIOD_NS = 100;
    localparam int DRAIN_TIME_NS = 1000;
    localparam int DRAIN_CYC_INT = (DRAIN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [10:0] DRAIN_CYC = 11'(DRAIN_CYC_INT < 1 ? 1 : DRAIN_CYC_INT);
    // fixed shutter speeds, exposure in lines per index
    localparam logic [10:0] SPEED_LINES [10] = '{11'd1060, 11'd530, 11'd265, 11'd130, 11'd65,
                                                 11'd32, 11'd16, 11'd8, 11'd4, 11'd1};
    typedef enum logic [1:0] {
        CAP_CONT = 2'b00,
        CAP_EDGE = 2'b01,
        CAP_WIDTH = 2'b10,
        CAP_DELAY = 2'b11
    } tet_cap_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_DUMP = 3'b001,
        ST_WAIT_LINE = 3'b010,
        ST_DRAIN = 3'b011,
        ST_EXPOSE = 3'b100,
        ST_HOLD = 3'b101,
        ST_READOUT = 3'b110
    } tet_state_t;
    typedef struct packed {
        logic multi_exposure_enable;
        logic [1:0] readout_region_select;
        logic vertical_merge_enable;
        logic dump_before_expose;
        logic restart_on_trigger_enable;
        logic shutter_kind;
        logic line_align_select;
        tet_cap_t capture_mode_select;
    } tet_cfg_t;
    typedef struct packed {
        logic frame_valid_out;
        logic line_valid_out;
        logic data_valid_out;
        logic exposure_active_out_n;
        logic pixel_clk_out;
    } tet_vid_t;
endpackage

/* File: core/tet_timing.sv */
`timescale 1ns/1ps
// Operation
// - full scan 1060/1030 lines, 1592/1380 pixels
// - partial scans use 1552 pixels, own line counts
// - capture modes 1, 2, 3 select trigger behaviour
// - align 0: expose from next line pulse
// - align 1: restart line, drain, then expose
// - shutter kind picks fixed index or custom lines
// - exposure counted in the mode's own lines
// - restart on trigger only in edge mode
// - merge only together with full scan
// - partial regions only with merge off
// - dump 133 lines before accumulation starts
// - multiple exposure only in frame-delay mode
// - edge mode ends exposure by shutter time
// - exposure output during accumulation, frame valid readout
// - width mode: leading edge start, trailing stop
// - delay mode: readout only at trailing edge
// - grabber strobes, exposure output low while exposing
module tet_timing (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [3:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [31:0] rdata,
    input wire logic trigger_in,
    input wire logic multi_shot_in,
    output tet_pkg::tet_vid_t video
);
    import tet_pkg::*;
    // ********************
    // pin synchronisers
    // ********************
    logic trig_s1_q, trig_s2_q, trig_s3_q, msh_s1_q, msh_s2_q, msh_s3_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            trig_s1_q <= 1'b0;
            trig_s2_q <= 1'b0;
            trig_s3_q <= 1'b0;
            msh_s1_q <= 1'b0;
            msh_s2_q <= 1'b0;
            msh_s3_q <= 1'b0;
        end else begin
            trig_s1_q <= trigger_in;
            trig_s2_q <= trig_s1_q;
            trig_s3_q <= trig_s2_q;
            msh_s1_q <= multi_shot_in;
            msh_s2_q <= msh_s1_q;
            msh_s3_q <= msh_s2_q;
        end
    end
    logic trig_rise, trig_fall, msh_rise;
    assign trig_rise = trig_s2_q & ~trig_s3_q;
    assign trig_fall = ~trig_s2_q & trig_s3_q;
    assign msh_rise = msh_s2_q & ~msh_s3_q;
    // ********************
    // register file
    // ********************
    tet_cfg_t shadow_q, shadow_d, cfg_q, cfg_d, shadow_ok;
    logic [31:0] expo_q, expo_d, rdata_q, rdata_d;
    tet_state_t state_q, state_d;
    logic [2:0] mcnt_q, mcnt_d;
    tet_vid_t vid_q, vid_d;
    always_comb begin
        shadow_d = shadow_q;
        expo_d = expo_q;
        rdata_d = 32'h0000_0000;
        if (wr_stb && addr == ADDR_CTRL) begin
            shadow_d = tet_cfg_t'(wdata[9:0]);
        end
        if (wr_stb && addr == ADDR_EXPO) begin
            expo_d = {12'h000, wdata[19:16], 5'h00, wdata[10:0]};
        end
        if (rd_stb) begin
            case (addr)
                ADDR_CTRL: rdata_d = {22'h00_0000, shadow_q};
                ADDR_EXPO: rdata_d = expo_q;
                ADDR_STAT: rdata_d = {25'h000_0000, mcnt_q, vid_q.frame_valid_out, state_q};
                default: rdata_d = 32'h0000_0000;
            endcase
        end
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            shadow_q <= tet_cfg_t'(CTRL_RESET[9:0]);
            expo_q <= EXPO_RESET;
            rdata_q <= 32'h0000_0000;
        end else begin
            shadow_q <= shadow_d;
            expo_q <= expo_d;
            rdata_q <= rdata_d;
        end
    end
    assign rdata = rdata_q;
    // illegal combinations are dropped when a setting is taken over
    always_comb begin
        shadow_ok = shadow_q;
        if (shadow_q.readout_region_select != 2'b00) begin
            shadow_ok.vertical_merge_enable = 1'b0;
        end
        if (shadow_q.capture_mode_select != CAP_EDGE) begin
            shadow_ok.restart_on_trigger_enable = 1'b0;
        end
        if (shadow_ok.restart_on_trigger_enable) begin
            shadow_ok.dump_before_expose = 1'b0;
        end
        if (shadow_q.capture_mode_select != CAP_DELAY) begin
            shadow_ok.multi_exposure_enable = 1'b0;
        end
    end
    // ********************
    // scan geometry per mode
    // ********************
    logic [10:0] px_total, ln_total, ln_out, exp_lines;
    always_comb begin
        px_total = cfg_q.vertical_merge_enable ? PX_MERGE : PX_FULL;
        ln_total = cfg_q.vertical_merge_enable ? LN_MERGE : LN_FULL;
        ln_out = cfg_q.vertical_merge_enable ? LN_MERGE_OUT : LN_FULL_OUT;
        case (cfg_q.readout_region_select)
            2'b01: begin
                px_total = PX_PART;
                ln_total = LN_HALF;
                ln_out = LN_HALF_OUT;
            end
            2'b10: begin
                px_total = PX_PART;
                ln_total = LN_QUART;
                ln_out = LN_QUART_OUT;
            end
            2'b11: begin
                px_total = PX_PART;
                ln_total = LN_EIGHTH;
                ln_out = LN_EIGHTH_OUT;
            end
            default: begin
            end
        endcase
        if (cfg_q.shutter_kind) begin
            exp_lines = expo_q[10:0];
        end else if (expo_q[19:16] > 4'h9) begin
            exp_lines = SPEED_LINES[9];
        end else begin
            exp_lines = SPEED_LINES[expo_q[19:16]];
        end
        if (exp_lines == 11'd0) begin
            exp_lines = 11'd1;
        end
    end
    // ********************
    // scan counters and sequencer
    // ********************
    logic [10:0] px_q, px_d, ln_q, ln_d, cnt_q, cnt_d;
    logic line_end, frame_end, start_exp;
    assign line_end = (px_q == px_total - 11'd1);
    assign frame_end = line_end && (ln_q == ln_total - 11'd1);
    always_comb begin
        state_d = state_q;
        cfg_d = cfg_q;
        cnt_d = cnt_q;
        mcnt_d = mcnt_q;
        start_exp = 1'b0;
        // line length follows the active geometry
        px_d = line_end ? 11'd0 : px_q + 11'd1;
        ln_d = frame_end ? 11'd0 : (line_end ? ln_q + 11'd1 : ln_q);
        case (state_q)
            ST_IDLE: begin
                if (frame_end) begin
                    cfg_d = shadow_ok;
                end
                // pending setting decides, it is applied with this trigger
                if (trig_rise && shadow_ok.capture_mode_select != CAP_CONT) begin
                    start_exp = 1'b1;
                end
            end
            ST_DUMP: begin
                if (line_end) begin
                    cnt_d = cnt_q + 11'd1;
                end
                if (line_end && cnt_q == DUMP_LINES - 11'd1) begin
                    state_d = ST_EXPOSE;
                    cnt_d = 11'd0;
                end
            end
            ST_WAIT_LINE: begin
                if (line_end) begin
                    state_d = ST_EXPOSE;
                end
            end
            ST_DRAIN: begin
                cnt_d = cnt_q + 11'd1;
                if (cnt_q == DRAIN_CYC - 11'd1) begin
                    state_d = ST_EXPOSE;
                    cnt_d = 11'd0;
                end
            end
            ST_EXPOSE: begin
                if (line_end) begin
                    cnt_d = cnt_q + 11'd1;
                end
                if (cfg_q.capture_mode_select == CAP_WIDTH) begin
                    if (trig_fall) begin
                        state_d = ST_READOUT;
                        px_d = 11'd0;
                        ln_d = 11'd0;
                    end
                end else if (line_end && cnt_q == exp_lines - 11'd1) begin
                    cnt_d = 11'd0;
                    // shutter time alone ends edge mode
                    if (cfg_q.capture_mode_select == CAP_EDGE) begin
                        state_d = ST_READOUT;
                        px_d = 11'd0;
                        ln_d = 11'd0;
                    end else begin
                        state_d = ST_HOLD;
                    end
                end
            end
            ST_HOLD: begin
                if (trig_fall) begin
                    state_d = ST_READOUT;
                    px_d = 11'd0;
                    ln_d = 11'd0;
                end else if (msh_rise && cfg_q.multi_exposure_enable && mcnt_q < MULTI_MAX - 3'd1) begin
                    state_d = ST_EXPOSE;
                    mcnt_d = mcnt_q + 3'd1;
                end
            end
            ST_READOUT: begin
                if (frame_end) begin
                    state_d = ST_IDLE;
                    cfg_d = shadow_ok;
                end
                // restart drops the frame in progress
                if (trig_rise && cfg_q.restart_on_trigger_enable) begin
                    start_exp = 1'b1;
                end
                // other triggers are not looked at here
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        if (start_exp) begin
            // a trigger also opens a fresh frame
            if (state_q == ST_IDLE) begin
                cfg_d = shadow_ok;
            end
            cnt_d = 11'd0;
            mcnt_d = 3'd0;
            if (cfg_d.line_align_select) begin
                // line timing restarts at the edge
                px_d = 11'd0;
                ln_d = 11'd0;
            end
            if (cfg_d.dump_before_expose) begin
                state_d = ST_DUMP;
            end else if (cfg_d.line_align_select) begin
                state_d = ST_DRAIN;
            end else begin
                state_d = ST_WAIT_LINE;
            end
        end
    end
    // ********************
    // grabber strobes
    // ********************
    logic readout_now, act_px;
    assign readout_now = (state_d == ST_READOUT) ||
        (state_d == ST_IDLE && (cfg_d.capture_mode_select == CAP_CONT || cfg_d.restart_on_trigger_enable));
    assign act_px = readout_now && ln_d < ln_out && px_d < PX_OUT;
    always_comb begin
        vid_d.exposure_active_out_n = (state_d != ST_EXPOSE);
        vid_d.frame_valid_out = readout_now && ln_d < ln_out;
        vid_d.line_valid_out = act_px;
        vid_d.data_valid_out = act_px;
        // pixel clock toggles every clk, one cycle per two pixel periods
        vid_d.pixel_clk_out = ~vid_q.pixel_clk_out;
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= ST_IDLE;
            cfg_q <= tet_cfg_t'(CTRL_RESET[9:0]);
            px_q <= 11'd0;
            ln_q <= 11'd0;
            cnt_q <= 11'd0;
            mcnt_q <= 3'd0;
            vid_q <= 5'b0_0010;
        end else begin
            state_q <= state_d;
            cfg_q <= cfg_d;
            px_q <= px_d;
            ln_q <= ln_d;
            cnt_q <= cnt_d;
            mcnt_q <= mcnt_d;
            vid_q <= vid_d;
        end
    end
    assign video = vid_q;
    // ********************
    // checks
    // ********************
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence s_dump_done;
        state_q == ST_DUMP && line_end && cnt_q == DUMP_LINES - 11'd1;
    endsequence
    a_dump_then_expose: assert property (s_dump_done |=> state_q == ST_EXPOSE)
        else $error("dump did not lead to exposure");
    a_dump_no_early: assert property (state_q == ST_DUMP && !(line_end && cnt_q == 11'd132)
        |=> state_q == ST_DUMP)
        else $error("dump left early");
    a_align_line_start: assert property (state_q == ST_WAIT_LINE && line_end |=> state_q == ST_EXPOSE)
        else $error("aligned start missed line pulse");
    a_drain_length: assert property (state_q == ST_DRAIN && cnt_q < DRAIN_CYC - 11'd1 |=> state_q == ST_DRAIN)
        else $error("drain pulse too short");
    a_exp_out_low: assert property (!vid_q.exposure_active_out_n == (state_q == ST_EXPOSE))
        else $error("exposure output not low");
    a_width_stop: assert property (state_q == ST_EXPOSE && cfg_q.capture_mode_select == CAP_WIDTH && trig_fall
        |=> state_q == ST_READOUT ##1 vid_q.frame_valid_out)
        else $error("width mode did not stop at trailing edge");
    a_hold_waits: assert property (state_q == ST_HOLD && !trig_fall |=> state_q != ST_READOUT)
        else $error("delay readout before trailing edge");
    a_busy_ignore: assert property (state_q == ST_READOUT && !cfg_q.restart_on_trigger_enable
        |=> state_q == ST_READOUT || state_q == ST_IDLE)
        else $error("trigger disturbed readout");
    a_cfg_boundary: assert property (cfg_q != $past(cfg_q) |-> $past(state_q == ST_IDLE || frame_end))
        else $error("settings changed mid frame");
    a_merge_full_only: assert property (cfg_q.vertical_merge_enable |-> cfg_q.readout_region_select == 2'b00)
        else $error("merge with partial scan");
    a_multi_limit: assert property (mcnt_q < MULTI_MAX)
        else $error("too many exposures");
    a_px_range: assert property (px_q < px_total && ln_q < ln_total)
        else $error("scan counter out of range");
endmodule

/* File: dv/tet_far_end.sv */
`timescale 1ns/1ps
// ********************
// trigger source and grabber model
// ********************
module tet_far_end (
    input wire logic clk,
    input wire logic rstn,
    input wire logic link_clk,
    input wire tet_pkg::tet_vid_t video,
    output logic trigger_in,
    output logic multi_shot_in,
    output int exp_len,
    output int lv_len
);
    import tet_pkg::*;
    int exp_cnt;
    int lv_cnt;
    initial begin
        trigger_in = 1'b0;
        multi_shot_in = 1'b0;
    end
    // pulse edges
    // launched on the link clock so edges never line up with clk
    task automatic pulse_pin(input bit which, input bit lvl);
        @(posedge link_clk);
        if (which) begin
            multi_shot_in <= lvl;
        end else begin
            trigger_in <= lvl;
        end
    endtask
    // grabber side: lengths of the last exposure and line strobes
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            exp_cnt <= 0;
            exp_len <= 0;
            lv_cnt <= 0;
            lv_len <= 0;
        end else begin
            if (!video.exposure_active_out_n) begin
                exp_cnt <= exp_cnt + 1;
            end else begin
                if (exp_cnt != 0) exp_len <= exp_cnt;
                exp_cnt <= 0;
            end
            if (video.line_valid_out) begin
                lv_cnt <= lv_cnt + 1;
            end else begin
                if (lv_cnt != 0) lv_len <= lv_cnt;
                lv_cnt <= 0;
            end
        end
    end
endmodule

/* File: dv/test_triggered_exposure_timing.sv */
`timescale 1ns/1ps
module test_triggered_exposure_timing;
    import tet_pkg::*;
    localparam int FV = 4;
    localparam int LV = 3;
    localparam int EXN = 1;
    logic clk, rstn, link_clk, wr_stb, rd_stb, trigger_in, multi_shot_in;
    logic [3:0] addr;
    logic [31:0] wdata, rdata, rv, seed;
    tet_vid_t video;
    int exp_len, lv_len, miscompares, n_checks, i;
    tet_timing DUT (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
        .rdata(rdata), .trigger_in(trigger_in), .multi_shot_in(multi_shot_in), .video(video));
    tet_far_end far (.clk(clk), .rstn(rstn), .link_clk(link_clk), .video(video), .trigger_in(trigger_in),
        .multi_shot_in(multi_shot_in), .exp_len(exp_len), .lv_len(lv_len));
    // ********************
    // clocks, watchdog, shared tasks
    // ********************
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        link_clk = 1'b0;
        #37;
        forever #400 link_clk = ~link_clk;
    end
    initial begin
        #9_900_000;
        miscompares++;
        $display("ERROR %0t: watchdog expired", $time);
        complete_run();
    end
    task automatic complete_run();
        $display("checks %0d, mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t: value %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic check_rng(input int got, input int lo, input int hi);
        n_checks++;
        if (got < lo || got > hi) begin
            miscompares++;
            $display("ERROR %0t: count %0d outside %0d..%0d", $time, got, lo, hi);
        end
    endtask
    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
    endtask
    task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        #1;
        d = rdata;
    endtask
    task automatic wait_vid(input int b, input logic lvl, input int maxc, output int c);
        c = 0;
        while (video[b] !== lvl && c < maxc) begin
            @(posedge clk);
            #1;
            c++;
        end
        if (video[b] !== lvl) begin
            miscompares++;
            $display("ERROR %0t: video bit %0d wait timed out", $time, b);
        end
    endtask
    task automatic restart();
        far.pulse_pin(0, 0);
        far.pulse_pin(1, 0);
        @(posedge clk);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
    endtask
    function automatic logic [31:0] cfg(input logic [1:0] m, input logic al, input logic sk, input logic mg,
        input logic [1:0] rg, input logic ml);
        return {22'h0, ml, rg, mg, 2'b00, sk, al, m};
    endfunction
    // merge survives only with full scan
    function automatic int line_len(input logic mg, input logic [1:0] rg);
        if (rg != 2'd0) return int'(PX_PART);
        return mg ? int'(PX_MERGE) : int'(PX_FULL);
    endfunction
    // ********************
    // scenarios
    // ********************
    task automatic test_regs();
        logic p;
        logic [31:0] w;
        restart();
        reg_rd(ADDR_CTRL, rv);
        check_val(rv, CTRL_RESET);
        reg_rd(ADDR_EXPO, rv);
        check_val(rv, EXPO_RESET);
        reg_wr(4'hc, 32'hffff_ffff);
        reg_rd(4'hc, rv);
        check_val(rv, 32'h0000_0000);
        @(posedge clk);
        #1;
        check_val(rdata, 32'h0000_0000);
        w = $random(seed) & 32'h000f_07ff;
        reg_wr(ADDR_EXPO, w);
        reg_rd(ADDR_EXPO, rv);
        check_val(rv, w);
        reg_wr(ADDR_STAT, 32'hffff_ffff);
        reg_rd(ADDR_STAT, rv);
        check_val(rv & 32'h7, 32'h0);
        p = video.pixel_clk_out;
        @(posedge clk);
        #1;
        check_val(video.pixel_clk_out, {31'h0, ~p});
        $display("register test done");
    endtask
    task automatic test_edge(input logic al, input logic sk, input logic mg, input logic [1:0] rg,
        input logic [10:0] n, input logic [3:0] idx, input logic rs);
        int c, len, ln, ex;
        len = line_len(mg, rg);
        ln = sk ? int'(n) : int'(SPEED_LINES[idx]);
        // drain eats the start of the first line
        ex = ln * len - (al ? int'(DRAIN_CYC) : 0);
        restart();
        reg_wr(ADDR_EXPO, {12'h000, idx, 5'h00, n});
        reg_wr(ADDR_CTRL, cfg(2'd1, al, sk, mg, rg, 1'b0) | {27'h0, rs, 4'h0});
        far.pulse_pin(0, 1);
        wait_vid(EXN, 1'b0, 2 * len + 40, c);
        if (al) check_rng(c, 12, 18);
        if (!al) check_rng(c, 3, len + 6);
        wait_vid(EXN, 1'b1, ln * len + 40, c);
        @(posedge clk);
        #1;
        check_rng(exp_len, ex - 2, ex + 2);
        wait_vid(FV, 1'b1, len + 40, c);
        check_rng(c, 0, 0);
        check_val(video.data_valid_out, 1'b1);
        repeat (len + 20) @(posedge clk);
        if (rs) wait_vid(LV, 1'b0, len, c);
        far.pulse_pin(0, 0);
        far.pulse_pin(0, 1);
        repeat (20) @(posedge clk);
        reg_rd(ADDR_STAT, rv);
        check_val(rv & 32'h7, rs ? 32'h4 : 32'h6);
        check_val(video.exposure_active_out_n, {31'h0, !rs});
        wait_vid(LV, 1'b0, len, c);
        @(posedge clk);
        #1;
        check_rng(lv_len, int'(PX_OUT), int'(PX_OUT));
        check_val(video.frame_valid_out, {31'h0, !rs});
        $display("edge test done, %0d lines of %0d", ln, len);
    endtask
    task automatic test_width(input logic al, input int hold);
        int c;
        restart();
        reg_wr(ADDR_CTRL, cfg(2'd2, al, 1'b0, 1'b0, 2'd2, 1'b0));
        far.pulse_pin(0, 1);
        wait_vid(EXN, 1'b0, 2 * int'(PX_PART) + 40, c);
        repeat (hold * int'(PX_PART)) @(posedge clk);
        check_val(video.exposure_active_out_n, 1'b0);
        far.pulse_pin(0, 0);
        #1;
        wait_vid(EXN, 1'b1, 20, c);
        check_rng(c, 3, 7);
        wait_vid(FV, 1'b1, 2 * int'(PX_PART), c);
        check_val(video.frame_valid_out, 1'b1);
        $display("width test done");
    endtask
    task automatic test_delay(input logic ml);
        int c, len;
        len = int'(PX_PART);
        restart();
        reg_wr(ADDR_EXPO, 32'h0000_0002);
        reg_wr(ADDR_CTRL, cfg(2'd3, 1'b1, 1'b1, 1'b0, 2'd1, ml));
        far.pulse_pin(0, 1);
        wait_vid(EXN, 1'b0, 60, c);
        wait_vid(EXN, 1'b1, 2 * len + 40, c);
        repeat (2 * len) @(posedge clk);
        reg_rd(ADDR_STAT, rv);
        check_val(rv & 32'h7, 32'h5);
        check_val(video.frame_valid_out, 1'b0);
        far.pulse_pin(1, 1);
        far.pulse_pin(1, 0);
        if (ml) wait_vid(EXN, 1'b0, 2 * len + 40, c);
        if (ml) wait_vid(EXN, 1'b1, 2 * len + 40, c);
        repeat (2 * len + 20) @(posedge clk);
        reg_rd(ADDR_STAT, rv);
        check_val((rv >> 4) & 32'h7, {31'h0, ml});
        far.pulse_pin(0, 0);
        wait_vid(FV, 1'b1, 2 * len + 40, c);
        check_val(video.frame_valid_out, 1'b1);
        $display("delay test done, multi %0d", ml);
    endtask
    initial begin
        seed = 32'h04f1;
        rstn = 1'b0;
        addr = 4'h0;
        wdata = 32'h0000_0000;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        miscompares = 0;
        n_checks = 0;
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        test_regs();
        for (i = 0; i < 2; i++) begin
            test_edge(i[0], 1'b1, 1'b0, 2'd3, 11'(1 + ($unsigned($random(seed)) % 3)), 4'd0, 1'b0);
        end
        test_edge(1'b0, 1'b0, 1'b0, 2'd3, 11'd0, 4'd8, 1'b0);
        test_edge(1'b0, 1'b1, 1'b1, 2'd0, 11'd1, 4'd0, 1'b0);
        test_edge(1'b1, 1'b1, 1'b1, 2'd3, 11'd1, 4'd0, 1'b1);
        test_width($unsigned($random(seed)) % 2, 2 + ($unsigned($random(seed)) % 2));
        test_delay(1'b0);
        test_delay(1'b1);
        complete_run();
    end
endmodule
